/* File: bfm_defines.svh */
/*
 constants for the bit-field memory unit and microword fetch path.
 assumes inclusion by bare name from the package; the design files rely on that and do not include it.
*/
`ifndef BFM_DEFINES_SVH
`define BFM_DEFINES_SVH
`define BFM_ADDR_W 24
`define BFM_LEN_W 5
`define BFM_DATA_W 24
`define BFM_MEM_BYTES 8192
`define BFM_MEM_AW 13
`define BFM_LEN_MAX 5'h18
`define BFM_LEN_PAR_OK 5'h19
`define BFM_LEN_PAR_BAD 5'h1a
`define BFM_MW_W 16
`define BFM_MAR_W 19
`define BFM_MAR_LOW 4
`define BFM_BR_W 12
`define BFM_PARITY_BIT 3
`define BFM_MW_STEP 19'h00010
`endif

/* File: bfm_pkg.sv */
/*
 types shared by the memory unit and its helpers.
 assumes bfm_defines.svh is on the include path.
*/
`include "bfm_defines.svh"
package bfm_pkg;
    typedef enum logic [1:0] {BFM_OP_READ, BFM_OP_WRITE, BFM_OP_SWAP} bfm_op_type;
    typedef enum logic [1:0] {BFM_MAR_HOLD, BFM_MAR_ADD, BFM_MAR_SUB, BFM_MAR_LOAD} bfm_mar_type;
    typedef logic [8:0] bfm_byte_type;
endpackage

/* File: bfm_parity_check.sv */
/*
 odd parity check across four staged bytes, one checker per byte.
 assumes bytes carry parity in bit 8 and odd parity is correct.
*/
`timescale 1ns/10ps
module bfm_parity_check
    import bfm_pkg::*;
(
    // staged bytes
    input wire logic [35:0] staged,
    // result
    output logic error
);
    logic [3:0] bad;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_byte
            assign bad[g] = ~(^staged[g*9 +: 9]);
        end
    endgenerate
    assign error = |bad;
endmodule

/* File: bfm_field_align.sv */
/*
 bit-field extract and merge over a 32-bit window in address order.
 assumes the window's bit 0 is the lowest address of the staged bytes.
*/
`timescale 1ns/10ps
module bfm_field_align
    import bfm_pkg::*;
(
    // window and field
    input wire logic [31:0] window,
    input wire logic [4:0] offset,
    input wire logic [4:0] length,
    input wire logic [23:0] wdata,
    // results
    output logic [23:0] rdata,
    output logic [31:0] merged
);
    logic [31:0] mask;
    logic [31:0] shifted;
    always_comb
    begin
        mask = (32'h00000001 << length) - 32'h00000001;
        shifted = window >> offset;
        rdata = shifted[23:0] & mask[23:0];
        merged = (window & ~(mask << offset)) | (({8'h00, wdata} & mask) << offset);
    end
endmodule

/* File: bfm_memory_unit.sv */
/*
 bit-addressable memory unit with byte parity and microword fetch path.
 assumes the processor holds request fields stable until done pulses.
*/
// Behaviour
// - request carries 24-bit bit address, direction flag and 5-bit length
// - direction chooses upward or downward bits; length counts bits
// - reverse access covers bits just below the given address
// - length zero does nothing and leaves memory unchanged
// - codes 25 and 26 write 24 bits with good or bad parity
// - storage is bytes of eight data bits plus one parity bit
// - upper 21 address bits select the starting byte
// - starting byte plus three neighbours load the read staging register
// - parity checked on all 36 staged bits every access
// - low address bits, length and direction select the field bits
// - parity error sets bit 3 of the processor state nibble
// - data right-adjusted on 24 bits; zero-filled reads, ignored high writes
// - reads keep memory intact and return masked right-adjusted data
// - microword register takes low 16 bits, zero-filled
// - fetched microword is ORed into the microword register
// - microword address register is 19 bits; low four ignored for addressing
// - microword address register adds or subtracts 0 to 4095
// - each fetch advances by sixteen bits, wrapping freely
// - reading the microword address register shows zero low bits
// - writing it stores the low four source bits anyway
// - data access saves next microword address, uses field address register
// - field address register holds absolute bit address of data field
`timescale 1ns/10ps
module bfm_memory_unit
    import bfm_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // data request
    input wire logic req_valid,
    input wire bfm_pkg::bfm_op_type req_op,
    input wire logic req_reverse,
    input wire logic [4:0] req_length,
    input wire logic [23:0] req_wdata,
    output logic req_done,
    output logic [23:0] req_rdata,
    // field address register
    input wire logic fa_load,
    input wire logic [23:0] fa_wdata,
    output logic [23:0] field_address_register,
    // microword path
    input wire logic fetch_req,
    output logic fetch_done,
    input wire logic mw_load,
    input wire logic [23:0] mw_wdata,
    output logic [15:0] microword_register,
    input wire bfm_pkg::bfm_mar_type mar_cmd,
    input wire logic [11:0] mar_increment,
    input wire logic [23:0] mar_wdata,
    output logic [18:0] mar_source,
    output logic [18:0] scratch_hold,
    // status
    input wire logic nibble_clear,
    output logic [3:0] processor_state_nibble
);
    import bfm_pkg::*;

    typedef enum logic [2:0] {BFM_IDLE, BFM_STAGE, BFM_CHECK, BFM_COMMIT, BFM_DONE} bfm_state_type;

    bfm_byte_type mem [0:`BFM_MEM_BYTES-1];
    bfm_state_type state_q;
    logic is_fetch_q;
    logic [35:0] staging_q;
    logic [1:0] stage_idx_q;
    logic [18:0] mar_q;
    logic [18:0] hold_q;
    logic [23:0] fa_q;
    logic [15:0] mw_q;
    logic [23:0] rdata_q;
    logic [3:0] nibble_q;
    logic done_q;
    logic fetch_done_q;

    logic [23:0] cur_addr;
    logic cur_rev;
    logic [4:0] cur_len;
    logic [20:0] base_byte;
    logic [4:0] offset;
    logic [4:0] eff_len;
    logic [31:0] window;
    logic [23:0] ext_data;
    logic [31:0] merged;
    logic par_err;
    logic [23:0] start_bit;
    logic [`BFM_MEM_AW-1:0] stage_addr;

    // a fetch reads 16 bits forward from the microword address, low bits dropped
    always_comb
    begin
        if (is_fetch_q)
        begin
            cur_addr = {5'h00, mar_q[18:4], 4'h0};
            cur_rev = 1'b0;
            cur_len = 5'h10;
        end
        else
        begin
            cur_addr = fa_q;
            cur_rev = req_reverse;
            cur_len = req_length;
        end
    end

    // reverse field ends at the given address: start that many bits lower
    assign eff_len = (cur_len > `BFM_LEN_MAX) ? `BFM_LEN_MAX : cur_len;
    assign start_bit = cur_rev ? (cur_addr - {19'h00000, eff_len}) : cur_addr;
    // reverse staging takes the key byte and three below it
    assign base_byte = cur_rev ? (cur_addr[23:3] - 21'h000003) : cur_addr[23:3];
    assign offset = 5'(start_bit - {base_byte, 3'h0});
    assign stage_addr = `BFM_MEM_AW'(base_byte + {19'h00000, stage_idx_q});

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_win
            assign window[g*8 +: 8] = staging_q[g*9 +: 8];
        end
    endgenerate

    bfm_parity_check u_parity (
        .staged(staging_q),
        .error(par_err)
    );

    bfm_field_align u_align (
        .window(window),
        .offset(offset),
        .length(eff_len),
        .wdata(req_wdata),
        .rdata(ext_data),
        .merged(merged)
    );

    // request sequencer
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= BFM_IDLE;
            is_fetch_q <= 1'b0;
            stage_idx_q <= 2'h0;
        end
        else if (clk_en)
        begin
            unique case (state_q)
                BFM_IDLE:
                begin
                    stage_idx_q <= 2'h0;
                    if (req_valid)
                    begin
                        is_fetch_q <= 1'b0;
                        state_q <= BFM_STAGE;
                    end
                    else if (fetch_req)
                    begin
                        is_fetch_q <= 1'b1;
                        state_q <= BFM_STAGE;
                    end
                end
                BFM_STAGE:
                begin
                    stage_idx_q <= stage_idx_q + 2'h1;
                    if (stage_idx_q == 2'h3)
                    begin
                        state_q <= BFM_CHECK;
                    end
                end
                BFM_CHECK:
                begin
                    state_q <= BFM_COMMIT;
                end
                BFM_COMMIT:
                begin
                    state_q <= BFM_DONE;
                end
                BFM_DONE:
                begin
                    state_q <= BFM_IDLE;
                end
                default:
                begin
                    state_q <= BFM_IDLE;
                end
            endcase
        end
    end

    // staging register fill, one byte per cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            staging_q <= 36'h000000000;
        end
        else if (clk_en && state_q == BFM_STAGE)
        begin
            staging_q[stage_idx_q*9 +: 9] <= mem[stage_addr];
        end
    end

    // write-back: only writes and swaps with nonzero length touch memory
    always_ff @(posedge ref_clk)
    begin
        if (clk_en && state_q == BFM_COMMIT && !is_fetch_q && req_op != BFM_OP_READ && req_length != 5'h00)
        begin : wr
            integer i;
            logic p;
            for (i = 0; i < 4; i++)
            begin
                p = ~(^merged[i*8 +: 8]);
                if (req_length == `BFM_LEN_PAR_BAD)
                begin
                    p = ~p;
                end
                mem[`BFM_MEM_AW'(base_byte + 21'(i))] <= {p, merged[i*8 +: 8]};
            end
        end
    end

    // read data: masked and right-adjusted, memory untouched
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rdata_q <= 24'h000000;
        end
        else if (clk_en && state_q == BFM_COMMIT && !is_fetch_q && req_op != BFM_OP_WRITE)
        begin
            rdata_q <= (req_length == 5'h00) ? 24'h000000 : ext_data;
        end
    end

    // parity status; hardware set beats software clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            nibble_q <= 4'h0;
        end
        else if (clk_en)
        begin
            if (state_q == BFM_CHECK && par_err)
            begin
                nibble_q[`BFM_PARITY_BIT] <= 1'b1;
            end
            else if (nibble_clear)
            begin
                nibble_q[`BFM_PARITY_BIT] <= 1'b0;
            end
        end
    end

    // done pulses
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            done_q <= 1'b0;
            fetch_done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_q <= (state_q == BFM_COMMIT) && !is_fetch_q;
            fetch_done_q <= (state_q == BFM_COMMIT) && is_fetch_q;
        end
    end

    // microword register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mw_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (state_q == BFM_COMMIT && is_fetch_q)
            begin
                mw_q <= mw_q | ext_data[15:0];
            end
            else if (mw_load)
            begin
                mw_q <= mw_wdata[15:0];
            end
        end
    end

    // microword address register; a fetch advance wins over software moves
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            mar_q <= 19'h00000;
        end
        else if (clk_en)
        begin
            if (state_q == BFM_COMMIT && is_fetch_q)
            begin
                mar_q <= mar_q + `BFM_MW_STEP;
            end
            else
            begin
                unique case (mar_cmd)
                    BFM_MAR_HOLD: mar_q <= mar_q;
                    BFM_MAR_ADD: mar_q <= mar_q + {7'h00, mar_increment};
                    BFM_MAR_SUB: mar_q <= mar_q - {7'h00, mar_increment};
                    BFM_MAR_LOAD: mar_q <= mar_wdata[18:0];
                endcase
            end
        end
    end

    // next microword address parked while data access runs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            hold_q <= 19'h00000;
        end
        else if (clk_en && state_q == BFM_IDLE && req_valid)
        begin
            hold_q <= mar_q;
        end
    end

    // field address register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            fa_q <= 24'h000000;
        end
        else if (clk_en && fa_load && state_q == BFM_IDLE)
        begin
            fa_q <= fa_wdata;
        end
    end

    assign req_done = done_q;
    assign fetch_done = fetch_done_q;
    assign req_rdata = rdata_q;
    assign field_address_register = fa_q;
    assign microword_register = mw_q;
    assign mar_source = {mar_q[18:4], 4'h0};
    assign scratch_hold = hold_q;
    assign processor_state_nibble = nibble_q;

    // a frozen enable holds every register, the done pulse included, so only enabled cycles count
    a_done_single: assert property (@(posedge ref_clk) disable iff (reset)
        (req_done && clk_en) |=> !req_done) else $error("done pulse lasted more than one cycle");
    a_done_timing: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_COMMIT && !is_fetch_q && clk_en) |=> req_done)
        else $error("done missing after commit");
    a_parity_sets: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_CHECK && par_err && clk_en) |=> processor_state_nibble[3])
        else $error("parity error not flagged");
    a_mar_low_zero: assert property (@(posedge ref_clk) disable iff (reset)
        mar_source[3:0] == 4'h0) else $error("microword address low bits not zero");
    a_fetch_step: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_COMMIT && is_fetch_q && clk_en) |=> mar_q == $past(mar_q) + 19'h00010)
        else $error("fetch did not advance by one word");
    a_fetch_or: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_COMMIT && is_fetch_q && clk_en) |=> (microword_register & $past(mw_q)) == $past(mw_q))
        else $error("fetch cleared microword bits");
    a_zero_read: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_COMMIT && !is_fetch_q && req_length == 5'h00 && req_op == BFM_OP_READ && clk_en)
        |=> req_rdata == 24'h000000) else $error("zero length read returned data");
    a_hold_saved: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_IDLE && req_valid && clk_en) |=> scratch_hold == $past(mar_q))
        else $error("next microword address not saved");
    a_stage_len: assert property (@(posedge ref_clk) disable iff (reset)
        (state_q == BFM_IDLE && (req_valid || fetch_req) && clk_en) |=> state_q == BFM_STAGE)
        else $error("request not staged");
endmodule

/* File: bfm_proc_model.sv */
/*
 processor model issuing field requests to the memory unit.
 assumes the bench starts one request at a time with go and waits for busy to drop.
*/
`timescale 1ns/10ps
module bfm_proc_model
    import bfm_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // command from the bench
    input wire logic go,
    input wire bfm_pkg::bfm_op_type op,
    input wire logic rev,
    input wire logic [4:0] len,
    input wire logic [23:0] addr,
    input wire logic [23:0] wdata,
    output logic busy,
    // memory unit side
    output logic fa_load,
    output logic [23:0] fa_wdata,
    input wire logic [23:0] field_address_register,
    output logic req_valid,
    output bfm_pkg::bfm_op_type req_op,
    output logic req_reverse,
    output logic [4:0] req_length,
    output logic [23:0] req_wdata,
    input wire logic req_done
);
    int n;
    initial
    begin
        busy = 1'b0;
        fa_load = 1'b0;
        fa_wdata = 24'h000000;
        req_valid = 1'b0;
        req_op = BFM_OP_READ;
        req_reverse = 1'b0;
        req_length = 5'h00;
        req_wdata = 24'h000000;
        forever
        begin
            @(posedge ref_clk);
            if (go === 1'b1)
            begin
                busy <= 1'b1;
                fa_load <= 1'b1;
                fa_wdata <= addr;
                n = 0;
                @(posedge ref_clk);
                // fa_load is ignored while busy or frozen, so hold it until it shows
                while (field_address_register !== addr && n < 40)
                begin
                    @(posedge ref_clk);
                    n++;
                end
                fa_load <= 1'b0;
                fa_wdata <= ~addr;
                req_valid <= 1'b1;
                req_op <= op;
                req_reverse <= rev;
                req_length <= len;
                req_wdata <= wdata;
                n = 0;
                @(posedge ref_clk);
                while (req_done !== 1'b1 && n < 80)
                begin
                    @(posedge ref_clk);
                    n++;
                end
                req_valid <= 1'b0;
                req_wdata <= ~wdata;
                while (req_done === 1'b1 && n < 80)
                begin
                    @(posedge ref_clk);
                    n++;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: bfm_memory_unit_tb.sv */
/*
 self-checking bench for the bit-field memory unit and microword path.
 assumes the design files and bfm_proc_model are compiled before it.
*/
`timescale 1ns/10ps
module bfm_memory_unit_tb;
    import bfm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic stall = 1'b0;
    logic go = 1'b0;
    bfm_op_type op = BFM_OP_READ;
    logic rev = 1'b0;
    logic [4:0] len = 5'h00;
    logic [23:0] addr = 24'h000000;
    logic [23:0] wdata = 24'h000000;
    logic fetch_req = 1'b0;
    logic mw_load = 1'b0;
    logic [23:0] mw_wdata = 24'h000000;
    bfm_mar_type mar_cmd = BFM_MAR_HOLD;
    logic [11:0] mar_increment = 12'h000;
    logic [23:0] mar_wdata = 24'h000000;
    logic nibble_clear = 1'b0;
    logic busy, fa_load, req_valid, req_reverse, req_done, fetch_done;
    bfm_op_type req_op;
    logic [4:0] req_length;
    logic [23:0] fa_wdata, req_wdata, req_rdata, field_address_register;
    logic [15:0] microword_register, mwexp;
    logic [18:0] mar_source, scratch_hold, mexp;
    logic [3:0] processor_state_nibble;
    logic [2111:0] img;
    logic [31:0] seed = 32'h0000002a;
    logic [31:0] r;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    bfm_proc_model host (.ref_clk, .go, .op, .rev, .len, .addr, .wdata, .busy, .fa_load, .fa_wdata,
        .field_address_register, .req_valid, .req_op, .req_reverse, .req_length, .req_wdata, .req_done);
    bfm_memory_unit dut (.ref_clk, .reset, .clk_en, .req_valid, .req_op, .req_reverse, .req_length,
        .req_wdata, .req_done, .req_rdata, .fa_load, .fa_wdata, .field_address_register, .fetch_req,
        .fetch_done, .mw_load, .mw_wdata, .microword_register, .mar_cmd, .mar_increment, .mar_wdata,
        .mar_source, .scratch_hold, .nibble_clear, .processor_state_nibble);

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // reference image of the low memory, one entry per bit address
    function automatic logic [23:0] fld(input logic rv, input int l, input int a);
        logic [23:0] v;
        v = 24'h000000;
        for (int i = 0; i < l; i++) v[i] = img[(rv ? a - l : a) + i];
        return v;
    endfunction

    task automatic put(input logic rv, input int l, input int a, input logic [23:0] d);
        for (int i = 0; i < l; i++) img[(rv ? a - l : a) + i] = d[i];
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic clr;
        nibble_clear <= 1'b1;
        tick(1);
        nibble_clear <= 1'b0;
        tick(2);
    endtask

    task automatic op_chk(input bfm_op_type o, input logic rv, input logic [4:0] l, input int a,
        input logic [23:0] d);
        logic [23:0] e;
        int k;
        // parity codes move a full 24-bit field
        k = l > 5'd24 ? 24 : int'(l);
        e = fld(rv, k, a);
        op <= o;
        rev <= rv;
        len <= l;
        addr <= 24'(a);
        wdata <= d;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(1);
        while (busy === 1'b1) tick(1);
        if (o != BFM_OP_WRITE) check(req_rdata, e);
        if (o != BFM_OP_READ) put(rv, k, a, d);
        check(field_address_register, 24'(a));
        check({5'h00, scratch_hold[18:4], 4'h0}, {5'h00, mexp[18:4], 4'h0});
    endtask

    task automatic mar_op(input bfm_mar_type c, input logic [11:0] i, input logic [18:0] w);
        mar_cmd <= c;
        mar_increment <= i;
        mar_wdata <= {5'h00, w};
        tick(1);
        mar_cmd <= BFM_MAR_HOLD;
        tick(2);
        mexp = c == BFM_MAR_LOAD ? w : (c == BFM_MAR_ADD ? mexp + 19'(i) : mexp - 19'(i));
        check({5'h00, mar_source}, {5'h00, mexp[18:4], 4'h0});
    endtask

    task automatic fetch;
        int n;
        mwexp = mwexp | 16'(fld(1'b0, 16, int'({mexp[18:4], 4'h0})));
        fetch_req <= 1'b1;
        n = 0;
        tick(1);
        while (fetch_done !== 1'b1 && n < 80)
        begin
            tick(1);
            n++;
        end
        fetch_req <= 1'b0;
        tick(2);
        mexp = mexp + 19'h00010;
        check({8'h00, microword_register}, {8'h00, mwexp});
        check({5'h00, mar_source}, {5'h00, mexp[18:4], 4'h0});
    endtask

    // the enable is only thinned out while data requests run
    always @(posedge ref_clk) clk_en <= stall ? rnd() % 4 != 0 : 1'b1;

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            end_sim();
        end
    end

    initial
    begin
        img = '0;
        mexp = 19'h00000;
        mwexp = 16'h0000;
        tick(8);
        reset <= 1'b0;
        tick(1);
        check({8'h00, microword_register}, 24'h000000);
        check({5'h00, mar_source}, 24'h000000);
        // array is not reset, so every byte used later gets written first
        for (int a = 0; a < 2064; a += 24) op_chk(BFM_OP_WRITE, 1'b0, 5'h18, a, 24'(rnd()));
        clr();
        check({20'h0, processor_state_nibble}, 24'h000000);
        op_chk(BFM_OP_WRITE, 1'b0, 5'h0c, 532, 24'h000345);
        op_chk(BFM_OP_READ, 1'b1, 5'h0c, 544, 24'h000000);
        check(req_rdata, 24'h000345);
        op_chk(BFM_OP_WRITE, 1'b0, 5'h00, 600, 24'hffffff);
        op_chk(BFM_OP_READ, 1'b0, 5'h18, 600, 24'h000000);
        op_chk(BFM_OP_WRITE, 1'b0, 5'h1a, 400, 24'(rnd()));
        check({20'h0, processor_state_nibble}, 24'h000000);
        op_chk(BFM_OP_READ, 1'b0, 5'h08, 408, 24'h000000);
        check({20'h0, processor_state_nibble}, 24'h000008);
        clr();
        op_chk(BFM_OP_SWAP, 1'b0, 5'h19, 400, 24'(rnd()));
        clr();
        op_chk(BFM_OP_READ, 1'b1, 5'h18, 424, 24'h000000);
        check({20'h0, processor_state_nibble}, 24'h000000);
        mw_load <= 1'b1;
        mw_wdata <= 24'h123456;
        tick(1);
        mw_load <= 1'b0;
        tick(2);
        mwexp = 16'h3456;
        check({8'h00, microword_register}, 24'h003456);
        mar_op(BFM_MAR_LOAD, 12'h000, 19'h0010f);
        mar_op(BFM_MAR_ADD, 12'h001, 19'h00000);
        fetch();
        fetch();
        mar_op(BFM_MAR_ADD, 12'hfff, 19'h00000);
        mar_op(BFM_MAR_SUB, 12'hfff, 19'h00000);
        mar_op(BFM_MAR_LOAD, 12'h000, 19'h00005);
        mar_op(BFM_MAR_SUB, 12'h010, 19'h00000);
        for (int i = 0; i < 8; i++) mar_op(rnd() % 2 == 0 ? BFM_MAR_ADD : BFM_MAR_SUB, 12'(rnd()), 19'h0);
        stall = 1'b1;
        repeat (80)
        begin
            r = rnd();
            op_chk(r[1:0] == 2'h3 ? BFM_OP_SWAP : bfm_op_type'(r[1:0]), r[2],
                r[12:8] == 5'h00 ? 5'h19 : r[7:3] % 5'd25, 64 + int'(r[31:16] % 16'd1700), 24'(rnd()));
            check({20'h0, processor_state_nibble}, 24'h000000);
        end
        stall = 1'b0;
        tick(2);
        end_sim();
    end
endmodule
